//--- e1pm_rx_perf_mon.sv
// E1 receive performance monitor: counters, alarm latches, remote alarm timing, AXI4-Lite slave.
// Assumes all event inputs come from framer logic on mclk, so none is synchronised here.
//
// Contract
// - Count 125 us frame periods spent out of basic frame sync, 8 bits.
// - Clear the sync-loss counter when sync is lost.
// - Count all bit errors in received alignment words, 8 bits.
// - Sticky flag when A high, E low lasted between 10 and 450 ms; read clears.
// - Indicator while A high, E low has lasted over 10 ms.
// - Count alignment words with one or more errors, 8 bits.
// - Alarm latch bit 7 set on remote alarm; read clears.
// - Alarm latch bit 6 set on all-ones alarm; read clears.
// - Alarm latch bit 5 set on timeslot 16 all-ones; read clears.
// - Alarm latch bit 4 set on loss of signal; read clears.
// - Alarm latch bit 3 set on auxiliary pattern; read clears.
// - Alarm latch bit 2 set on multiframe alarm; read clears.
// - Alarm latch bit 1 set on elastic buffer slip; bit 0 unused.
// - Count bipolar violations in 16 bits, high byte 1C, low byte 1D.
// - Per-counter overflow flags in the overflow register, cleared by reading it.
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module e1pm_rx_perf_mon
   import e1pm_pkg::*;
#(
   parameter int unsigned SET_CYCLES = REMOTE_SET_CYCLES,
   parameter int unsigned MAX_CYCLES = REMOTE_MAX_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic frame_tick,
   input wire logic basic_sync,
   input wire e1pm_fas_type fas_check,
   input wire logic rx_a_bit,
   input wire logic rx_e_bit,
   input wire logic line_violation,
   input wire e1pm_alarm_type alarm_event,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic continuous_remote_crc_indicator,
   output logic irq
);

   localparam logic [HOLD_W-1:0] SET_LIM = HOLD_W'(SET_CYCLES);
   localparam logic [HOLD_W-1:0] MAX_LIM = HOLD_W'(MAX_CYCLES);

   logic sync_held_reg;
   logic [7:0] sync_loss_period_count_reg;
   logic [7:0] alignment_bit_error_count_reg;
   logic [7:0] errored_alignment_word_count_reg;
   logic [15:0] line_violation_count_reg;
   logic [7:0] overflow_reg;
   logic [7:0] alarm_latch_reg;
   logic windowed_remote_crc_flag_reg;
   logic continuous_remote_crc_reg;
   logic [HOLD_W-1:0] hold_cnt_reg;
   logic [2:0] irq_status_reg, irq_mask_reg;
   logic irq_reg;
   logic arready_reg, rvalid_reg, awready_reg, bvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg, bresp_reg;

   logic ar_take, aw_take;
   logic [5:0] rd_idx, wr_idx;
   logic rd_overflow, rd_alarm, rd_remote, rd_status;
   logic remote_held, sync_lost_edge, window_hit, rd_mapped;
   logic [8:0] bit_err_sum;
   logic [7:0] alarm_set, ovf_set;
   logic [2:0] irq_set;
   logic [31:0] rd_word;

   assign rd_idx = s_axi_araddr[7:2];
   assign wr_idx = s_axi_awaddr[7:2];
   assign ar_take = s_axi_arvalid && arready_reg;
   assign aw_take = s_axi_awvalid && s_axi_wvalid && awready_reg;
   assign rd_overflow = ar_take && (rd_idx == IDX_OVERFLOW);
   assign rd_alarm = ar_take && (rd_idx == IDX_ALARM_LATCH);
   assign rd_remote = ar_take && (rd_idx == IDX_REMOTE_CRC);
   assign rd_status = ar_take && (rd_idx == IDX_IRQ_STATUS);
   assign remote_held = rx_a_bit && !rx_e_bit;
   assign sync_lost_edge = sync_held_reg && !basic_sync;
   assign bit_err_sum = {1'b0, alignment_bit_error_count_reg} + {6'h00, fas_check.bit_errors};
   assign window_hit = !remote_held && (hold_cnt_reg > SET_LIM) && (hold_cnt_reg < MAX_LIM);

   ////////////////////////////////////////////////////////////////////////////
   // Performance counters. They wrap, and each wrap raises an overflow flag.

   always_ff @(posedge mclk) begin
      if (rst) begin
         sync_held_reg <= 1'b0;
         sync_loss_period_count_reg <= CNT8_RESET;
      end else begin
         sync_held_reg <= basic_sync;
         if (sync_lost_edge) begin
            sync_loss_period_count_reg <= CNT8_RESET;
         end else if (frame_tick && !basic_sync) begin
            sync_loss_period_count_reg <= sync_loss_period_count_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         alignment_bit_error_count_reg <= CNT8_RESET;
         errored_alignment_word_count_reg <= CNT8_RESET;
      end else if (fas_check.checked) begin
         alignment_bit_error_count_reg <= bit_err_sum[7:0];
         if (fas_check.bit_errors != 3'h0) begin
            errored_alignment_word_count_reg <= errored_alignment_word_count_reg + 8'h01;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         line_violation_count_reg <= CNT16_RESET;
      end else if (line_violation) begin
         line_violation_count_reg <= line_violation_count_reg + 16'h0001;
      end
   end

   always_comb begin
      ovf_set = 8'h00;
      ovf_set[OVF_SYNC_LOSS_BIT] = !sync_lost_edge && frame_tick && !basic_sync &&
                                   (sync_loss_period_count_reg == 8'hff);
      ovf_set[OVF_ALIGN_BIT_ERR_BIT] = fas_check.checked && bit_err_sum[8];
      ovf_set[OVF_ERR_ALIGN_BIT] = fas_check.checked && (fas_check.bit_errors != 3'h0) &&
                                   (errored_alignment_word_count_reg == 8'hff);
      ovf_set[OVF_VIOL_BIT] = line_violation && (line_violation_count_reg == 16'hffff);
   end

   // Set wins over the read clear so that a wrap in the read cycle is reported next time.
   always_ff @(posedge mclk) begin
      if (rst) begin
         overflow_reg <= LATCH_RESET;
      end else begin
         overflow_reg <= (overflow_reg & ~{8{rd_overflow}}) | ovf_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Alarm reporting latches.

   always_comb begin
      alarm_set = 8'h00;
      alarm_set[ALM_REMOTE_BIT] = alarm_event.remote_alarm;
      alarm_set[ALM_ALL_ONES_BIT] = alarm_event.all_ones;
      alarm_set[ALM_TS16_BIT] = alarm_event.ts16_all_ones;
      alarm_set[ALM_ABSENT_BIT] = alarm_event.signal_absent;
      alarm_set[ALM_AUX_BIT] = alarm_event.auxiliary_pattern;
      alarm_set[ALM_MFRAME_BIT] = alarm_event.multiframe_alarm;
      alarm_set[ALM_SLIP_BIT] = alarm_event.elastic_slip;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         alarm_latch_reg <= LATCH_RESET;
      end else begin
         alarm_latch_reg <= (alarm_latch_reg & ~{8{rd_alarm}}) | alarm_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Remote alarm with CRC error timing. The hold counter saturates so that a
   // condition held far beyond the upper window cannot wrap back into it.

   always_ff @(posedge mclk) begin
      if (rst) begin
         hold_cnt_reg <= '0;
      end else if (!remote_held) begin
         hold_cnt_reg <= '0;
      end else if (hold_cnt_reg != {HOLD_W{1'b1}}) begin
         hold_cnt_reg <= hold_cnt_reg + HOLD_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         continuous_remote_crc_reg <= 1'b0;
      end else begin
         continuous_remote_crc_reg <= remote_held && (hold_cnt_reg >= SET_LIM);
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         windowed_remote_crc_flag_reg <= 1'b0;
      end else if (window_hit) begin
         windowed_remote_crc_flag_reg <= 1'b1;
      end else if (rd_remote) begin
         windowed_remote_crc_flag_reg <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt: sticky status cleared by reading it, gated by the mask.

   always_comb begin
      irq_set = 3'h0;
      irq_set[IRQ_ALARM_BIT] = |alarm_set;
      irq_set[IRQ_OVERFLOW_BIT] = |ovf_set;
      irq_set[IRQ_REMOTE_CRC_BIT] = window_hit;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         irq_status_reg <= IRQ_MASK_RESET;
         irq_reg <= 1'b0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~{3{rd_status}}) | irq_set;
         irq_reg <= |(irq_status_reg & irq_mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel. Both address and data must be offered before the
   // slave raises its readies, so neither is ever taken alone.

   always_ff @(posedge mclk) begin
      if (rst) begin
         awready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
         irq_mask_reg <= IRQ_MASK_RESET;
      end else if (aw_take) begin
         awready_reg <= 1'b0;
         bvalid_reg <= 1'b1;
         if (wr_idx == IDX_IRQ_MASK) begin
            bresp_reg <= RESP_OKAY;
            if (s_axi_wstrb[0]) begin
               irq_mask_reg <= s_axi_wdata[2:0];
            end
         end else if ((wr_idx >= IDX_OVERFLOW && wr_idx <= IDX_VIOL_LOW) || wr_idx == IDX_IRQ_STATUS) begin
            bresp_reg <= RESP_OKAY;
         end else begin
            bresp_reg <= RESP_SLVERR;
         end
      end else if (bvalid_reg) begin
         if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end else begin
         awready_reg <= s_axi_awvalid && s_axi_wvalid && !awready_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel. Read-clear takes effect at the address handshake,
   // the same edge at which the returned value is captured.

   always_comb begin
      rd_word = 32'h0000_0000;
      rd_mapped = 1'b1;
      unique case (rd_idx)
         IDX_OVERFLOW: rd_word[7:0] = overflow_reg;
         IDX_SYNC_LOSS: rd_word[7:0] = sync_loss_period_count_reg;
         IDX_ALIGN_BIT_ERR: rd_word[7:0] = alignment_bit_error_count_reg;
         IDX_REMOTE_CRC: rd_word[1:0] = {windowed_remote_crc_flag_reg, continuous_remote_crc_reg};
         IDX_ERR_ALIGN_WORD: rd_word[7:0] = errored_alignment_word_count_reg;
         IDX_ALARM_LATCH: rd_word[7:0] = alarm_latch_reg;
         IDX_VIOL_HIGH: rd_word[7:0] = line_violation_count_reg[15:8];
         IDX_VIOL_LOW: rd_word[7:0] = line_violation_count_reg[7:0];
         IDX_IRQ_STATUS: rd_word[2:0] = irq_status_reg;
         IDX_IRQ_MASK: rd_word[2:0] = irq_mask_reg;
         default: rd_mapped = 1'b0;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
      end else if (ar_take) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg) begin
         if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end else begin
         arready_reg <= 1'b1;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = awready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign continuous_remote_crc_indicator = continuous_remote_crc_reg;
   assign irq = irq_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_sync_tick;
      @(posedge mclk) disable iff (rst)
      (frame_tick && !basic_sync && !sync_lost_edge) |=>
         (sync_loss_period_count_reg == $past(sync_loss_period_count_reg) + 8'h01);
   endproperty
   a_sync_tick: assert property (p_sync_tick) else $error("sync-loss count did not advance");

   property p_sync_clear;
      @(posedge mclk) disable iff (rst)
      (sync_held_reg && !basic_sync) |=> (sync_loss_period_count_reg == 8'h00);
   endproperty
   a_sync_clear: assert property (p_sync_clear) else $error("sync-loss count not cleared");

   property p_bit_err;
      @(posedge mclk) disable iff (rst)
      fas_check.checked |=> (alignment_bit_error_count_reg ==
         $past(alignment_bit_error_count_reg) + {5'h00, $past(fas_check.bit_errors)});
   endproperty
   a_bit_err: assert property (p_bit_err) else $error("bit error count wrong");

   property p_window;
      @(posedge mclk) disable iff (rst)
      (!remote_held && hold_cnt_reg > SET_LIM && hold_cnt_reg < MAX_LIM) |=> windowed_remote_crc_flag_reg;
   endproperty
   a_window: assert property (p_window) else $error("windowed remote flag not set");

   property p_cont_ind;
      @(posedge mclk) disable iff (rst)
      continuous_remote_crc_reg |-> ($past(remote_held) && $past(hold_cnt_reg) >= SET_LIM);
   endproperty
   a_cont_ind: assert property (p_cont_ind) else $error("indicator high without cause");

   property p_cont_drop;
      @(posedge mclk) disable iff (rst)
      (continuous_remote_crc_reg && !remote_held) |=> !continuous_remote_crc_reg;
   endproperty
   a_cont_drop: assert property (p_cont_drop) else $error("indicator did not drop");

   property p_err_word;
      @(posedge mclk) disable iff (rst)
      (fas_check.checked && fas_check.bit_errors != 3'h0) |=>
         (errored_alignment_word_count_reg == $past(errored_alignment_word_count_reg) + 8'h01);
   endproperty
   a_err_word: assert property (p_err_word) else $error("errored word count wrong");

   property p_slip_wins;
      @(posedge mclk) disable iff (rst)
      (alarm_event.elastic_slip && rd_alarm) |=> alarm_latch_reg[ALM_SLIP_BIT];
   endproperty
   a_slip_wins: assert property (p_slip_wins) else $error("slip lost at clearing read");

   property p_remote_latch;
      @(posedge mclk) disable iff (rst)
      alarm_event.remote_alarm |=> alarm_latch_reg[ALM_REMOTE_BIT];
   endproperty
   a_remote_latch: assert property (p_remote_latch) else $error("remote alarm not latched");

   property p_viol;
      @(posedge mclk) disable iff (rst)
      line_violation |=> (line_violation_count_reg == $past(line_violation_count_reg) + 16'h0001);
   endproperty
   a_viol: assert property (p_viol) else $error("violation count wrong");

   property p_viol_ovf;
      @(posedge mclk) disable iff (rst)
      (line_violation && line_violation_count_reg == 16'hffff) |=> overflow_reg[OVF_VIOL_BIT];
   endproperty
   a_viol_ovf: assert property (p_viol_ovf) else $error("violation overflow not flagged");

   property p_unused_bit;
      @(posedge mclk) disable iff (rst)
      !alarm_latch_reg[0];
   endproperty
   a_unused_bit: assert property (p_unused_bit) else $error("unused alarm bit set");

endmodule // e1pm_rx_perf_mon

`default_nettype wire

//--- e1pm_pkg.sv
// Constants, register map and carrier types of the E1 receive performance monitor.
// Assumes a 100 MHz mclk and an AXI4-Lite master with 8-bit byte addresses.
package e1pm_pkg;

   // Register indices; the byte address is four times the index.
   localparam logic [5:0] IDX_OVERFLOW = 6'h16;
   localparam logic [5:0] IDX_SYNC_LOSS = 6'h17;
   localparam logic [5:0] IDX_ALIGN_BIT_ERR = 6'h18;
   localparam logic [5:0] IDX_REMOTE_CRC = 6'h19;
   localparam logic [5:0] IDX_ERR_ALIGN_WORD = 6'h1a;
   localparam logic [5:0] IDX_ALARM_LATCH = 6'h1b;
   localparam logic [5:0] IDX_VIOL_HIGH = 6'h1c;
   localparam logic [5:0] IDX_VIOL_LOW = 6'h1d;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h20;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

   // Overflow register bit positions.
   localparam int OVF_SYNC_LOSS_BIT = 4;
   localparam int OVF_ALIGN_BIT_ERR_BIT = 3;
   localparam int OVF_ERR_ALIGN_BIT = 2;
   localparam int OVF_VIOL_BIT = 1;

   // Alarm latch bit positions.
   localparam int ALM_REMOTE_BIT = 7;
   localparam int ALM_ALL_ONES_BIT = 6;
   localparam int ALM_TS16_BIT = 5;
   localparam int ALM_ABSENT_BIT = 4;
   localparam int ALM_AUX_BIT = 3;
   localparam int ALM_MFRAME_BIT = 2;
   localparam int ALM_SLIP_BIT = 1;

   // Interrupt status and mask bit positions.
   localparam int IRQ_ALARM_BIT = 0;
   localparam int IRQ_OVERFLOW_BIT = 1;
   localparam int IRQ_REMOTE_CRC_BIT = 2;

   // Reset values.
   localparam logic [7:0] CNT8_RESET = 8'h00;
   localparam logic [15:0] CNT16_RESET = 16'h0000;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

   // Remote alarm with CRC error timing.
   localparam int CLK_KHZ = 100_000;
   localparam int REMOTE_SET_MS = 10;
   localparam int REMOTE_MAX_MS = 450;
   localparam int REMOTE_SET_CYCLES = REMOTE_SET_MS * CLK_KHZ;
   localparam int REMOTE_MAX_CYCLES = REMOTE_MAX_MS * CLK_KHZ;
   localparam int HOLD_W = 26;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Alarm events from the framer, each a one-cycle pulse.
   typedef struct packed {
      logic remote_alarm;
      logic all_ones;
      logic ts16_all_ones;
      logic signal_absent;
      logic auxiliary_pattern;
      logic multiframe_alarm;
      logic elastic_slip;
   } e1pm_alarm_type;

   // Frame alignment word check result.
   typedef struct packed {
      logic checked;
      logic [2:0] bit_errors;
   } e1pm_fas_type;

endpackage

//--- e1pm_host.sv
// AXI4-Lite master model standing in for the host processor of the monitor.
// Assumes a slave on mclk; it never gives up a wait, the bench watchdog ends a hang.
`timescale 1ns/1ps
`default_nettype none

module e1pm_host (
   input wire logic mclk,
   output logic [7:0] s_axi_awaddr,
   output logic s_axi_awvalid,
   input wire logic s_axi_awready,
   output logic [31:0] s_axi_wdata,
   output logic [3:0] s_axi_wstrb,
   output logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   output logic s_axi_bready,
   output logic [7:0] s_axi_araddr,
   output logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   output logic s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address and data are offered together and each is dropped once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge mclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         ad |= s_axi_awready;
         wd |= s_axi_wready;
      end
      do @(posedge mclk); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
endmodule // e1pm_host

`default_nettype wire

//--- test_e1pm_rx_perf_mon.sv
// Self-checking bench of the E1 receive performance monitor.
// Assumes the host model and shortened remote alarm windows of 20 and 100 cycles.
`timescale 1ns/1ps
`default_nettype none

module test_e1pm_rx_perf_mon
   import e1pm_pkg::*;
;
   localparam int unsigned SC = 20;
   localparam int unsigned MC = 100;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic frame_tick = 1'b0;
   logic basic_sync = 1'b1;
   logic rx_a_bit = 1'b0;
   logic rx_e_bit = 1'b1;
   logic line_violation = 1'b0;
   e1pm_fas_type fas_check = '0;
   e1pm_alarm_type alarm_event = '0;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, continuous_remote_crc_indicator, irq;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   int fails = 0;
   int num_checks = 0;

   e1pm_rx_perf_mon #(.SET_CYCLES(SC), .MAX_CYCLES(MC)) uut (.mclk, .rst, .frame_tick, .basic_sync,
      .fas_check, .rx_a_bit, .rx_e_bit, .line_violation, .alarm_event, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .continuous_remote_crc_indicator, .irq);

   e1pm_host host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   initial forever #5 mclk = ~mclk;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      if (fails == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic rdc(input logic [5:0] x, input logic [31:0] e);
      logic [31:0] d;
      logic [1:0] r;
      host.rd({x, 2'b00}, d, r);
      chk($sformatf("reg %h", x), d, e);
      chk("rresp", 32'(r), 32'(RESP_OKAY));
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge mclk);
   endtask

   task automatic frames(input int k);
      repeat (k) begin
         @(posedge mclk) frame_tick <= 1'b1;
         @(posedge mclk) frame_tick <= 1'b0;
      end
   endtask

   // The indicator is looked at one edge late, so it shows only after SC + 2 held cycles.
   function automatic logic [31:0] exp_ind(input int unsigned n);
      return 32'(n > SC + 1);
   endfunction

   function automatic logic [31:0] exp_window(input int unsigned n);
      return (n > SC && n < MC) ? 32'h2 : 32'h0;
   endfunction

   function automatic logic [31:0] exp_fas_ovf(input int se, input int ne);
      return (32'(se > 255) << OVF_ALIGN_BIT_ERR_BIT) | (32'(ne > 255) << OVF_ERR_ALIGN_BIT);
   endfunction

   // Holds A high and E low for n sampled cycles, then checks both remote alarm outputs.
   task automatic rem(input int unsigned n);
      @(posedge mclk) rx_a_bit <= 1'b1;
      rx_e_bit <= 1'b0;
      step(n);
      chk("ind held", 32'(continuous_remote_crc_indicator), exp_ind(n));
      rx_a_bit <= 1'b0;
      rx_e_bit <= 1'b1;
      step(2);
      chk("ind ended", 32'(continuous_remote_crc_indicator), 32'h0);
      rdc(IDX_REMOTE_CRC, exp_window(n));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      int n, b, se, ne;
      logic [5:0] idx [10];
      idx = '{IDX_OVERFLOW, IDX_SYNC_LOSS, IDX_ALIGN_BIT_ERR, IDX_REMOTE_CRC, IDX_ERR_ALIGN_WORD,
         IDX_ALARM_LATCH, IDX_VIOL_HIGH, IDX_VIOL_LOW, IDX_IRQ_STATUS, IDX_IRQ_MASK};
      void'($urandom(32'h77b74a40));
      step(4);
      rst <= 1'b0;
      foreach (idx[i]) rdc(idx[i], 32'h0);
      host.rd(8'h78, d, r);
      chk("rd unmapped", 32'(r), 32'(RESP_SLVERR));
      chk("rd unmapped data", d, 32'h0);
      host.wr(8'h7c, 32'h1, r);
      chk("wr unmapped", 32'(r), 32'(RESP_SLVERR));
      host.wr({IDX_SYNC_LOSS, 2'b00}, 32'h5a, r);
      chk("wr read-only", 32'(r), 32'(RESP_OKAY));
      rdc(IDX_SYNC_LOSS, 32'h0);
      host.wr({IDX_IRQ_MASK, 2'b00}, 32'h1, r);
      for (int i = 0; i < 7; i++) begin
         @(posedge mclk) alarm_event <= 7'(1 << i);
         @(posedge mclk) alarm_event <= '0;
         step(2);
         chk("irq alarm", 32'(irq), 32'h1);
         rdc(IDX_ALARM_LATCH, 32'(2 << i));
         rdc(IDX_ALARM_LATCH, 32'h0);
      end
      step(3);
      // The slip pulse lands on the very edge that takes the clearing read.
      fork
         host.rd({IDX_ALARM_LATCH, 2'b00}, d, r);
         begin
            @(posedge mclk) alarm_event <= 7'h01;
            @(posedge mclk) alarm_event <= '0;
         end
      join
      rdc(IDX_ALARM_LATCH, 32'h2);
      rdc(IDX_IRQ_STATUS, 32'h1);
      step(2);
      chk("irq cleared", 32'(irq), 32'h0);
      n = $urandom_range(1, 300);
      for (int j = 0; j < 2; j++) begin
         repeat (j ? 65536 : n) @(posedge mclk) line_violation <= 1'b1;
         @(posedge mclk) line_violation <= 1'b0;
         rdc(IDX_VIOL_HIGH, 32'(n >> 8));
         rdc(IDX_VIOL_LOW, 32'(n & 255));
      end
      rdc(IDX_OVERFLOW, 32'(1 << OVF_VIOL_BIT));
      rdc(IDX_OVERFLOW, 32'h0);
      se = 0;
      ne = 0;
      repeat (300) begin
         b = $urandom_range(0, 7);
         se += b;
         ne += int'(b != 0);
         @(posedge mclk) fas_check <= '{1'b1, 3'(b)};
         @(posedge mclk) fas_check <= '0;
      end
      rdc(IDX_ALIGN_BIT_ERR, 32'(se & 255));
      rdc(IDX_ERR_ALIGN_WORD, 32'(ne & 255));
      rdc(IDX_OVERFLOW, exp_fas_ovf(se, ne));
      frames(1);
      @(posedge mclk) basic_sync <= 1'b0;
      step(2);
      n = $urandom_range(3, 20);
      frames(n);
      @(posedge mclk) basic_sync <= 1'b1;
      frames(2);
      rdc(IDX_SYNC_LOSS, 32'(n));
      @(posedge mclk) basic_sync <= 1'b0;
      step(2);
      rdc(IDX_SYNC_LOSS, 32'h0);
      frames(260);
      rdc(IDX_SYNC_LOSS, 32'h4);
      rdc(IDX_OVERFLOW, 32'(1 << OVF_SYNC_LOSS_BIT));
      rem(15);
      rem(50);
      rem(150);
      chk("irq masked", 32'(irq), 32'h0);
      host.wr({IDX_IRQ_MASK, 2'b00}, 32'h7, r);
      step(2);
      chk("irq unmasked", 32'(irq), 32'h1);
      rdc(IDX_IRQ_STATUS, 32'h6);
      step(2);
      chk("irq after clear", 32'(irq), 32'h0);
      rdc(IDX_IRQ_MASK, 32'h7);
      close_out();
   end

   // The whole run takes about 68,000 cycles, so 90,000 cycles only trips on a hang.
   initial begin
      #900_000;
      fails++;
      close_out();
   end
endmodule // test_e1pm_rx_perf_mon

`default_nettype wire
